// file: bench/mol_control_assertions.sv
// Assertion checker for the output and logger control block
`timescale 1ns/1ps
`default_nettype none
module mol_control_checker
   import mol_pkg::*;
#(
   parameter int OFF_HOLD_CYC = 50,
   parameter int MS_CYC = 10,
   parameter int AVG_W = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Inputs watched
   input wire mol_keys_type key_press,
   input wire logic escape_level,
   input wire logic trigger_in,
   input wire mol_send_mode_type interface_output_mode,
   input wire logic port_select,
   input wire mol_rec_mode_type recorder_mode,
   input wire logic measuring,
   input wire logic rate_edit,
   input wire logic [3:0] sensor_request,
   input wire logic sensor_load,
   // Outputs watched
   input wire mol_cmd_type cmd,
   input wire logic power_on,
   input wire logic [9:0] rate_active,
   input wire logic [3:0] sensor_set
);
   int unsigned hold_cnt;
   // Cycles escape has been held
   always_ff @(posedge clk or posedge rst)
      if (rst)
         hold_cnt <= 0;
      else
         hold_cnt <= escape_level ? hold_cnt + 1 : 0;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_trig_rise;
      $rose(trigger_in) && power_on && measuring &&
      interface_output_mode == MOL_SEND_TRIGGER;
   endsequence
   sequence s_trig_send;
      ##[2:6] (cmd.send_usb || cmd.send_rs232);
   endsequence
   a_trig_send: assert property (s_trig_rise |-> s_trig_send)
      else $error("trigger edge gave no send");
   a_manual_send: assert property (power_on && measuring && port_select &&
      interface_output_mode == MOL_SEND_MANUAL && key_press.confirm
      |=> cmd.send_usb) else $error("confirm gave no send");
   a_send_off: assert property (interface_output_mode == MOL_SEND_OFF &&
      $past(interface_output_mode) == MOL_SEND_OFF
      |-> !cmd.send_usb && !cmd.send_rs232) else $error("send while off");
   a_port_route: assert property (cmd.send_usb
      |-> !cmd.send_rs232 && $past(port_select)) else $error("wrong port");
   a_rec_off: assert property ($past(recorder_mode) == MOL_REC_OFF
      |-> !cmd.store) else $error("store while recorder off");
   a_power_up: assert property (!power_on && key_press.confirm
      |=> power_on) else $error("confirm did not power up");
   a_off_quiet: assert property (!power_on && !$past(power_on)
      |-> cmd == 5'h00) else $error("command while powered down");
   a_power_off: assert property (hold_cnt > OFF_HOLD_CYC + 1
      |-> !power_on) else $error("long escape did not power down");
   a_rate_keep: assert property (!(rate_edit && key_press.confirm)
      |=> $stable(rate_active)) else $error("rate changed unconfirmed");
   a_rate_range: assert property (rate_active >= 10'h001 &&
      rate_active <= 10'h3E8) else $error("rate out of range");
   a_sensor_load: assert property (sensor_load && sensor_request <= 4'h9
      |=> sensor_set == $past(sensor_request)) else $error("sensor not loaded");
endmodule
bind mol_control mol_control_checker #(.OFF_HOLD_CYC(OFF_HOLD_CYC),
   .MS_CYC(MS_CYC), .AVG_W(AVG_W)) i_mol_control_checker (.clk, .rst,
   .key_press, .escape_level, .trigger_in, .interface_output_mode,
   .port_select, .recorder_mode, .measuring, .rate_edit, .sensor_request,
   .sensor_load, .cmd, .power_on, .rate_active, .sensor_set);
`default_nettype wire

// file: bench/mol_control_bench.sv
// Testbench for the output and logger control block
`timescale 1ns/1ps
`default_nettype none
module mol_control_bench;
   import mol_pkg::*;
   localparam mol_keys_type K_OK = 4'h8;
   localparam mol_keys_type K_ESC = 4'h4;
   logic clk = 0, rst = 1, escape_level = 0, trigger_in = 0, port_select = 1;
   logic measuring = 1, recorder_readout = 0, recorder_clear = 0;
   logic rate_edit = 0, sensor_load = 0, pass_digit_valid = 0;
   logic remote_readout = 0, remote_clear = 0, sample_valid = 0;
   logic [21:0] send_interval_ms = 22'h00000A, store_interval_ms = 22'h00000A;
   logic [9:0] rate_candidate = 10'h001;
   logic [7:0] average_setting = 8'h01, average_count;
   logic [3:0] sensor_request = 4'h0, pass_digit = 4'h0, sensor_set;
   mol_keys_type key_press = '0;
   mol_send_mode_type interface_output_mode = MOL_SEND_MANUAL;
   mol_rec_mode_type recorder_mode = MOL_REC_OFF;
   mol_cmd_type cmd;
   logic power_on, adjust_unlocked, repeat_value;
   logic [9:0] rate_active;
   logic [15:0] n_usb, n_rs, n_st, n_rd, n_cl;
   logic [15:0] e_usb = 0, e_rs = 0, e_st = 0, e_rd = 0, e_cl = 0;
   int bad_count = 0, total_checks = 0;
   mol_control #(.OFF_HOLD_CYC(50), .MS_CYC(10), .AVG_W(8)) i_mol_control (
      .clk, .rst, .key_press, .escape_level, .trigger_in,
      .interface_output_mode, .send_interval_ms, .port_select, .recorder_mode,
      .store_interval_ms, .measuring, .recorder_readout, .recorder_clear,
      .rate_edit, .rate_candidate, .average_setting, .sensor_request,
      .sensor_load, .pass_digit, .pass_digit_valid, .remote_readout,
      .remote_clear, .sample_valid, .cmd, .power_on, .adjust_unlocked,
      .rate_active, .average_count, .sensor_set, .repeat_value);
   mol_link_receiver i_mol_link_receiver (.clk, .rst, .cmd,
      .usb_count(n_usb), .rs_count(n_rs), .store_count(n_st),
      .read_count(n_rd), .clear_count(n_cl));
   initial
      forever #12.5 clk = ~clk;
   task automatic test_done();
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic counts();
      tick(2);
      chk(n_usb, e_usb);
      chk(n_rs, e_rs);
      chk(n_st, e_st);
      chk(n_rd, e_rd);
      chk(n_cl, e_cl);
   endtask
   task automatic key(input mol_keys_type k);
      key_press = k;
      tick(1);
      key_press = '0;
      tick(1);
   endtask
   task automatic code(input logic [15:0] c);
      for (int i = 3; i >= 0; i--)
      begin
         pass_digit = c[i*4+:4];
         pass_digit_valid = 1;
         tick(1);
         pass_digit_valid = 0;
         tick(1);
      end
   endtask
   task automatic load(input logic [3:0] s);
      sensor_request = s;
      sensor_load = 1;
      tick(1);
      sensor_load = 0;
      tick(1);
   endtask
   initial
   begin
      tick(6);
      rst = 0;
      tick(1);
      chk(power_on, 0);
      chk(rate_active, 1);
      chk(sensor_set, 0);
      key(K_OK);
      chk(power_on, 1);
      key(K_OK);
      e_usb++;
      port_select = 0;
      key(K_OK);
      e_rs++;
      counts();
      interface_output_mode = MOL_SEND_OFF;
      recorder_mode = MOL_REC_MANUAL;
      key(K_OK);
      e_st++;
      counts();
      interface_output_mode = MOL_SEND_TRIGGER;
      recorder_mode = MOL_REC_EDGE;
      port_select = 1;
      trigger_in = 1;
      tick(10);
      trigger_in = 0;
      tick(10);
      e_usb++;
      e_st++;
      counts();
      interface_output_mode = MOL_SEND_PERIODIC;
      recorder_mode = MOL_REC_AUTO;
      tick(1050);
      interface_output_mode = MOL_SEND_MANUAL;
      recorder_mode = MOL_REC_OFF;
      e_usb += 10;
      e_st += 10;
      counts();
      chk(repeat_value, 1);
      sample_valid = 1;
      tick(1);
      sample_valid = 0;
      key(K_OK);
      chk(repeat_value, 0);
      key(K_OK);
      chk(repeat_value, 1);
      e_usb += 2;
      interface_output_mode = MOL_SEND_OFF;
      remote_readout = 1;
      tick(1);
      remote_readout = 0;
      remote_clear = 1;
      tick(1);
      remote_clear = 0;
      e_rd++;
      e_cl++;
      counts();
      recorder_mode = MOL_REC_GATED;
      trigger_in = 1;
      tick(45);
      trigger_in = 0;
      tick(30);
      recorder_mode = MOL_REC_OFF;
      e_st += 4;
      counts();
      measuring = 0;
      recorder_readout = 1;
      key(K_OK);
      key(K_OK);
      recorder_readout = 0;
      e_rd++;
      recorder_clear = 1;
      key(K_OK);
      key(K_ESC);
      key(K_OK);
      counts();
      key(K_OK);
      recorder_clear = 0;
      e_cl++;
      counts();
      rate_edit = 1;
      rate_candidate = 10'h3E8;
      average_setting = 8'h04;
      key(K_ESC);
      chk(rate_active, 10'h001);
      key(K_OK);
      chk(rate_active, 10'h3E8);
      chk(average_count, 8'h04);
      rate_candidate = 10'h3E9;
      key(K_OK);
      chk(rate_active, 10'h3E8);
      rate_edit = 0;
      load(4'h9);
      chk(sensor_set, 4'h9);
      load(4'hA);
      chk(sensor_set, 4'h9);
      code(16'h1373);
      chk(adjust_unlocked, 0);
      code(16'h9373);
      chk(adjust_unlocked, 1);
      escape_level = 1;
      tick(45);
      chk(power_on, 1);
      tick(10);
      chk(power_on, 0);
      escape_level = 0;
      test_done();
   end
   initial
   begin
      tick(5000);
      bad_count++;
      test_done();
   end
endmodule
`default_nettype wire

// file: bench/mol_link_receiver.sv
// Receiving end of the serial link, tallies what arrives
`timescale 1ns/1ps
`default_nettype none
module mol_link_receiver
   import mol_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Commands from the block
   input wire mol_cmd_type cmd,
   // Tallies
   output logic [15:0] usb_count,
   output logic [15:0] rs_count,
   output logic [15:0] store_count,
   output logic [15:0] read_count,
   output logic [15:0] clear_count
);
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         usb_count <= 16'h0000;
         rs_count <= 16'h0000;
         store_count <= 16'h0000;
         read_count <= 16'h0000;
         clear_count <= 16'h0000;
      end
      else
      begin
         usb_count <= usb_count + 16'(cmd.send_usb);
         rs_count <= rs_count + 16'(cmd.send_rs232);
         store_count <= store_count + 16'(cmd.store);
         read_count <= read_count + 16'(cmd.readout);
         clear_count <= clear_count + 16'(cmd.clear);
      end
endmodule
`default_nettype wire

// file: shared/mol_defines.svh
// Constants for the measure output and logger control block
`ifndef MOL_DEFINES_SVH
`define MOL_DEFINES_SVH
`define MOL_CLK_HZ 40000000
`define MOL_SEND_MIN_MS 10
`define MOL_SEND_MAX_MS 3600000
`define MOL_GATE_STORE_MS 1
`define MOL_GATE_CYC ((`MOL_CLK_HZ / 1000) * `MOL_GATE_STORE_MS)
`define MOL_MS_CYC (`MOL_CLK_HZ / 1000)
`define MOL_OFF_HOLD_MS 3000
`define MOL_OFF_HOLD_CYC ((`MOL_CLK_HZ / 1000) * `MOL_OFF_HOLD_MS + 1)
`define MOL_PASSWORD 16'h9373
`define MOL_RATE_MIN 1
`define MOL_RATE_MAX 1000
`define MOL_SENSOR_MAX 9
`define MOL_RATE_RESET 10'd1
`endif

// file: shared/mol_pkg.sv
// Types for the measure output and logger control block
package mol_pkg;
   typedef enum logic [1:0] {
      MOL_SEND_OFF,
      MOL_SEND_MANUAL,
      MOL_SEND_PERIODIC,
      MOL_SEND_TRIGGER
   } mol_send_mode_type;
   typedef enum logic [2:0] {
      MOL_REC_OFF,
      MOL_REC_MANUAL,
      MOL_REC_AUTO,
      MOL_REC_EDGE,
      MOL_REC_GATED
   } mol_rec_mode_type;
   typedef struct packed {
      logic confirm;
      logic escape;
      logic up;
      logic down;
   } mol_keys_type;
   typedef struct packed {
      logic send_usb;
      logic send_rs232;
      logic store;
      logic readout;
      logic clear;
   } mol_cmd_type;
endpackage

// file: verilog/mol_control.sv
// Output and logger trigger control of a portable measuring indicator
`timescale 1ns/1ps
`default_nettype none
`include "mol_defines.svh"
module mol_control
   import mol_pkg::*;
#(
   parameter int OFF_HOLD_CYC = `MOL_OFF_HOLD_CYC,
   parameter int MS_CYC = `MOL_MS_CYC,
   parameter int AVG_W = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Keys, one-cycle presses, plus escape held level
   input wire mol_keys_type key_press,
   input wire logic escape_level,
   // Trigger input, asynchronous pin
   input wire logic trigger_in,
   // Settings
   input wire mol_send_mode_type interface_output_mode,
   input wire logic [21:0] send_interval_ms,
   input wire logic port_select,
   input wire mol_rec_mode_type recorder_mode,
   input wire logic [21:0] store_interval_ms,
   input wire logic measuring,
   // Menu actions
   input wire logic recorder_readout,
   input wire logic recorder_clear,
   input wire logic rate_edit,
   input wire logic [9:0] rate_candidate,
   input wire logic [AVG_W-1:0] average_setting,
   input wire logic [3:0] sensor_request,
   input wire logic sensor_load,
   input wire logic [3:0] pass_digit,
   input wire logic pass_digit_valid,
   // Remote commands while measuring
   input wire logic remote_readout,
   input wire logic remote_clear,
   // Measurement source
   input wire logic sample_valid,
   // Outputs
   output mol_cmd_type cmd,
   output logic power_on,
   output logic adjust_unlocked,
   output logic [9:0] rate_active,
   output logic [AVG_W-1:0] average_count,
   output logic [3:0] sensor_set,
   output logic repeat_value
);
   initial
   begin
      if (MS_CYC < 1 || OFF_HOLD_CYC < 2 || AVG_W < 1)
         $error("mol_control: bad parameters");
   end

   logic trig_meta_reg, trig_sync_reg, trig_prev_reg;
   logic trig_rise, trig_fall;
   logic [31:0] ms_cnt_reg;
   logic ms_tick;
   logic [21:0] send_ms_reg, store_ms_reg;
   logic [31:0] gate_cnt_reg;
   logic gate_open_reg;
   logic [31:0] hold_cnt_reg;
   logic [1:0] readout_cnt_reg;
   logic clear_arm_reg;
   logic [1:0] pass_idx_reg;
   logic pass_ok_reg;
   logic fresh_reg;
   logic send_ev, store_ev;
   logic [3:0] pass_expect;

   // Trigger synchroniser and edge detect
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         trig_meta_reg <= 1'b0;
         trig_sync_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
      end
      else
      begin
         trig_meta_reg <= trigger_in;
         trig_sync_reg <= trig_meta_reg;
         trig_prev_reg <= trig_sync_reg;
      end
   end
   assign trig_rise = trig_sync_reg & ~trig_prev_reg;
   assign trig_fall = ~trig_sync_reg & trig_prev_reg;

   // Millisecond tick
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ms_cnt_reg <= 32'h0;
      else if (ms_tick)
         ms_cnt_reg <= 32'h0;
      else
         ms_cnt_reg <= ms_cnt_reg + 32'h1;
   end
   assign ms_tick = (ms_cnt_reg == 32'(MS_CYC - 1));

   // Periodic send interval, clamped to 10 ms .. 1 h
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         send_ms_reg <= 22'h0;
      else if (interface_output_mode != MOL_SEND_PERIODIC || !measuring)
         send_ms_reg <= 22'h0;
      else if (ms_tick)
      begin
         if (send_ms_reg + 22'h1 >= clamp_ms(send_interval_ms))
            send_ms_reg <= 22'h0;
         else
            send_ms_reg <= send_ms_reg + 22'h1;
      end
   end

   function automatic logic [21:0] clamp_ms(input logic [21:0] v);
      if (v < 22'(`MOL_SEND_MIN_MS))
         return 22'(`MOL_SEND_MIN_MS);
      else if (v > 22'(`MOL_SEND_MAX_MS))
         return 22'(`MOL_SEND_MAX_MS);
      else
         return v;
   endfunction

   // Automatic store interval
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         store_ms_reg <= 22'h0;
      else if (recorder_mode != MOL_REC_AUTO || !measuring)
         store_ms_reg <= 22'h0;
      else if (ms_tick)
      begin
         if (store_ms_reg + 22'h1 >= clamp_ms(store_interval_ms))
            store_ms_reg <= 22'h0;
         else
            store_ms_reg <= store_ms_reg + 22'h1;
      end
   end

   // Gated recording window
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         gate_open_reg <= 1'b0;
      else if (recorder_mode != MOL_REC_GATED || !measuring)
         gate_open_reg <= 1'b0;
      else if (trig_rise)
         gate_open_reg <= 1'b1;
      else if (trig_fall)
         gate_open_reg <= 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         gate_cnt_reg <= 32'h0;
      else if (!gate_open_reg ||
         gate_cnt_reg == 32'(MS_CYC * `MOL_GATE_STORE_MS - 1))
         gate_cnt_reg <= 32'h0;
      else
         gate_cnt_reg <= gate_cnt_reg + 32'h1;
   end

   // Send decision; recorder settings take no part
   always_comb
   begin
      send_ev = 1'b0;
      if (measuring)
      begin
         unique case (interface_output_mode)
            MOL_SEND_OFF: send_ev = 1'b0;
            MOL_SEND_MANUAL: send_ev = key_press.confirm;
            MOL_SEND_PERIODIC: send_ev = ms_tick &&
               (send_ms_reg + 22'h1 >= clamp_ms(send_interval_ms));
            MOL_SEND_TRIGGER: send_ev = trig_rise;
         endcase
      end
   end

   // Store decision
   always_comb
   begin
      store_ev = 1'b0;
      if (measuring)
      begin
         unique case (recorder_mode)
            MOL_REC_OFF: store_ev = 1'b0;
            MOL_REC_MANUAL: store_ev = key_press.confirm;
            MOL_REC_AUTO: store_ev = ms_tick &&
               (store_ms_reg + 22'h1 >= clamp_ms(store_interval_ms));
            MOL_REC_EDGE: store_ev = trig_rise;
            MOL_REC_GATED: store_ev = gate_open_reg &&
               gate_cnt_reg == 32'(MS_CYC * `MOL_GATE_STORE_MS - 1);
            default: store_ev = 1'b0;
         endcase
      end
   end

   // Registered commands
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cmd <= '0;
      else
      begin
         cmd.send_usb <= power_on & send_ev & port_select;
         cmd.send_rs232 <= power_on & send_ev & ~port_select;
         cmd.store <= power_on & store_ev;
         cmd.readout <= power_on & ((measuring & remote_readout) |
            (!measuring & recorder_readout & key_press.confirm &
            readout_cnt_reg == 2'd1));
         cmd.clear <= power_on & ((measuring & remote_clear) |
            (!measuring & recorder_clear & clear_arm_reg &
            key_press.confirm));
      end
   end

   // Readout needs two confirms, clear needs a confirmed query
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         readout_cnt_reg <= 2'd0;
         clear_arm_reg <= 1'b0;
      end
      else
      begin
         if (!recorder_readout || measuring || key_press.escape)
            readout_cnt_reg <= 2'd0;
         else if (key_press.confirm)
            readout_cnt_reg <= (readout_cnt_reg == 2'd1) ? 2'd0 : 2'd1;
         if (!recorder_clear || measuring || key_press.escape)
            clear_arm_reg <= 1'b0;
         else if (key_press.confirm)
            clear_arm_reg <= ~clear_arm_reg;
      end
   end

   // Power control by long escape and confirm
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         power_on <= 1'b0;
         hold_cnt_reg <= 32'h0;
      end
      else
      begin
         if (!power_on)
         begin
            hold_cnt_reg <= 32'h0;
            if (key_press.confirm)
               power_on <= 1'b1;
         end
         else if (!escape_level)
            hold_cnt_reg <= 32'h0;
         else if (hold_cnt_reg == 32'(OFF_HOLD_CYC - 1))
         begin
            power_on <= 1'b0;
            hold_cnt_reg <= 32'h0;
         end
         else
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
      end
   end

   // Password digits entered most significant first
   assign pass_expect = 4'(`MOL_PASSWORD >> (4 * (3 - pass_idx_reg)));
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pass_idx_reg <= 2'd0;
         pass_ok_reg <= 1'b1;
         adjust_unlocked <= 1'b0;
      end
      else if (!power_on)
      begin
         pass_idx_reg <= 2'd0;
         pass_ok_reg <= 1'b1;
         adjust_unlocked <= 1'b0;
      end
      else if (pass_digit_valid)
      begin
         pass_idx_reg <= pass_idx_reg + 2'd1;
         if (pass_idx_reg == 2'd3)
         begin
            adjust_unlocked <= pass_ok_reg && pass_digit == pass_expect;
            pass_ok_reg <= 1'b1;
         end
         else
            pass_ok_reg <= pass_ok_reg && pass_digit == pass_expect;
      end
   end

   // Rate, averaging and sensor selection
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rate_active <= `MOL_RATE_RESET;
         average_count <= AVG_W'(1);
         sensor_set <= 4'h0;
      end
      else
      begin
         if (rate_edit && key_press.confirm &&
            rate_candidate >= 10'(`MOL_RATE_MIN) &&
            rate_candidate <= 10'(`MOL_RATE_MAX))
            rate_active <= rate_candidate;
         if (rate_edit && key_press.confirm && average_setting != '0)
            average_count <= average_setting;
         if (sensor_load && sensor_request <= 4'(`MOL_SENSOR_MAX))
            sensor_set <= sensor_request;
      end
   end

   // Marks output that repeats a value already sent
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fresh_reg <= 1'b0;
         repeat_value <= 1'b0;
      end
      else
      begin
         if (send_ev)
         begin
            repeat_value <= ~(fresh_reg | sample_valid);
            fresh_reg <= 1'b0;
         end
         else if (sample_valid)
            fresh_reg <= 1'b1;
      end
   end
endmodule
`default_nettype wire
